// ==== logic/hpc_drive_scale.sv ====
/*
 maps the drive level code and acceleration enable to a signed q1.7 scale.
 assumes registered inputs.
*/
`default_nettype none
module hpc_drive_scale (
   input  wire logic       accel_en,
   input  wire logic [7:0] direct_drive_level,
   output logic      [7:0] scale_q7
);
   // negative codes clamp to zero under acceleration
   always_comb begin
      if (direct_drive_level[7] && accel_en) begin
         scale_q7 = 8'h00;
      end else begin
         scale_q7 = direct_drive_level;
      end
   end
endmodule
`default_nettype wire

// ==== logic/hpc_pkg.sv ====
/*
 register map, field positions, reset values and shared types of the haptic
 control register slice.
 assumes one 200 mhz clock and an axi4-lite master.
*/
// Contract
// - the conversion factor hold bit stops all automatic factor updates while set.
// - the calibration inhibit bit (reset 1) stops factor updates during playback.
// - locked is set while the tracking error is below four times the lock limit (reset 0x20).
// - a back-emf fault is raised below the selected threshold, and code 0 disables it; the code raises it only during playback.
// - the proportional coefficient is high byte (reset 0x0e) then low byte (reset 0x20).
// - the integral coefficient is high byte (reset 0x03) then low byte (reset 0x20).
// - the 3-bit brake cutoff threshold (reset 4) ends drive during braking.
// - the 4-bit tracking pause threshold (reset 3) pauses frequency tracking.
// - writing 1 to playback go starts playback (the code starts it only when the written mode is not 0), writing 0 stops it and returns to idle.
// - a finished playback ends in idle, or in standby when the standby bit is 1.
// - mode 0 is inactive, 1 direct override, 2 pwm, 3 register-triggered and 4 edge-triggered.
// - in direct override the drive scale follows the code, 0x7f full scale and 0x00 zero.
// - codes 0x80 to 0xff scale negative with acceleration off and give zero with it on.
// - active acceleration enable is bit 2 of a configuration register, reset 1.
`default_nettype none
package hpc_pkg;
   // byte address is four times the index
   localparam logic [7:0] IDX_CAL_CTRL   = 8'h16;
   localparam logic [7:0] IDX_LOCK_FAULT = 8'h17;
   localparam logic [7:0] IDX_PROP_HIGH  = 8'h1c;
   localparam logic [7:0] IDX_PROP_LOW   = 8'h1d;
   localparam logic [7:0] IDX_INTEG_HIGH = 8'h1e;
   localparam logic [7:0] IDX_INTEG_LOW  = 8'h1f;
   localparam logic [7:0] IDX_BRAKE_PAUSE = 8'h20;
   localparam logic [7:0] IDX_PLAY_CTRL  = 8'h22;
   localparam logic [7:0] IDX_DRIVE_LVL  = 8'h23;
   localparam logic [7:0] IDX_CONFIG     = 8'h30;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h31;
   localparam logic [7:0] IDX_IRQ_MASK   = 8'h32;
   localparam logic [7:0] IDX_STATE      = 8'h33;

   localparam logic [7:0] MASK_CAL_CTRL    = 8'hc0;
   localparam logic [7:0] MASK_BRAKE_PAUSE = 8'h7f;
   localparam logic [7:0] MASK_PLAY_CTRL   = 8'h1f;
   localparam logic [7:0] MASK_CONFIG      = 8'h04;
   localparam logic [7:0] MASK_IRQ         = 8'h07;

   localparam logic [7:0] RST_CAL_CTRL    = 8'h40;
   localparam logic [7:0] RST_LOCK_FAULT  = 8'h81;
   localparam logic [7:0] RST_PROP_HIGH   = 8'h0e;
   localparam logic [7:0] RST_PROP_LOW    = 8'h20;
   localparam logic [7:0] RST_INTEG_HIGH  = 8'h03;
   localparam logic [7:0] RST_INTEG_LOW   = 8'h20;
   localparam logic [7:0] RST_BRAKE_PAUSE = 8'h43;
   localparam logic [7:0] RST_PLAY_CTRL   = 8'h00;
   localparam logic [7:0] RST_DRIVE_LVL   = 8'h00;
   localparam logic [7:0] RST_CONFIG      = 8'h04;

   localparam int BIT_HOLD      = 7;
   localparam int BIT_INHIBIT   = 6;
   localparam int BIT_GO        = 4;
   localparam int BIT_STANDBY   = 3;
   localparam int BIT_ACCEL     = 2;
   localparam int IRQ_FAULT     = 0;
   localparam int IRQ_LOCK      = 1;
   localparam int IRQ_DONE      = 2;

   // back-emf fault thresholds in microvolts per code
   localparam logic [15:0] BEMF_UV_1 = 16'h1324;
   localparam logic [15:0] BEMF_UV_2 = 16'h6cfc;
   localparam logic [15:0] BEMF_UV_3 = 16'hc2ec;

   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      MODE_INACTIVE = 3'h0,
      MODE_DIRECT   = 3'h1,
      MODE_PWM      = 3'h2,
      MODE_REG_TRIG = 3'h3,
      MODE_EDGE_TRIG = 3'h4
   } hpc_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'h0,
      ST_PLAY    = 2'h1,
      ST_STANDBY = 2'h2
   } hpc_state_t;

   typedef struct packed {
      logic [15:0] prop_coeff;
      logic [15:0] integ_coeff;
      logic [2:0]  brake_cutoff_threshold;
      logic [3:0]  tracking_pause_threshold;
      logic [5:0]  lock_error_limit;
   } hpc_loop_cfg_t;
endpackage
`default_nettype wire

// ==== logic/hpc_regs.sv ====
/*
 haptic control register slice: calibration hold, limits, loop coefficients,
 playback control and drive level, with a small interrupt block.
 assumes one axi4-lite master and loop measurements synchronous to aclk.
*/
// The AXI4-Lite interface to the registers was chosen for this implementation.
`default_nettype none
module hpc_regs (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [15:0]       track_error,
   input  wire logic [15:0]       backemf_uv,
   input  wire logic              playback_done,
   input  wire logic              factor_update_req,
   output logic                   factor_update_en,
   output logic                   freq_locked,
   output logic                   backemf_fault,
   output logic                   playback_active,
   output logic                   standby_active,
   output logic [2:0]             active_mode,
   output logic [7:0]             drive_scale,
   output hpc_pkg::hpc_loop_cfg_t loop_cfg,
   output logic                   irq
);
   logic [7:0] cal_ctrl_reg;
   logic [7:0] lock_fault_reg;
   logic [7:0] prop_high_reg;
   logic [7:0] prop_low_reg;
   logic [7:0] integ_high_reg;
   logic [7:0] integ_low_reg;
   logic [7:0] brake_pause_reg;
   logic [7:0] play_ctrl_reg;
   logic [7:0] drive_lvl_reg;
   logic [7:0] config_reg;
   logic [7:0] irq_status_reg;
   logic [7:0] irq_mask_reg;
   hpc_pkg::hpc_state_t state_reg;
   hpc_pkg::hpc_state_t state_next;
   logic       aw_held_reg;
   logic       w_held_reg;
   logic [7:0] aw_addr_reg;
   logic [7:0] w_data_reg;
   logic       w_strb_reg;
   logic [7:0] scale_next;
   logic       lock_next;
   logic       fault_next;
   logic       wr_fire;
   logic       rd_fire;
   logic       go_wr1;
   logic       go_wr0;
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;
   logic [2:0] irq_events;

   // byte address to register index
   function automatic logic [7:0] to_idx(input logic [7:0] a);
      to_idx = {2'h0, a[7:2]};
   endfunction

   function automatic logic mapped(input logic [7:0] idx);
      case (idx)
         hpc_pkg::IDX_CAL_CTRL, hpc_pkg::IDX_LOCK_FAULT, hpc_pkg::IDX_PROP_HIGH,
         hpc_pkg::IDX_PROP_LOW, hpc_pkg::IDX_INTEG_HIGH, hpc_pkg::IDX_INTEG_LOW,
         hpc_pkg::IDX_BRAKE_PAUSE, hpc_pkg::IDX_PLAY_CTRL, hpc_pkg::IDX_DRIVE_LVL,
         hpc_pkg::IDX_CONFIG, hpc_pkg::IDX_IRQ_STATUS, hpc_pkg::IDX_IRQ_MASK,
         hpc_pkg::IDX_STATE: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   assign wr_idx = to_idx(aw_addr_reg);
   assign rd_idx = to_idx(s_axi_araddr);

   // address and data are caught apart, then committed together
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg   <= 1'b0;
         aw_addr_reg   <= 8'h00;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg   <= 1'b1;
         aw_addr_reg   <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
         aw_held_reg   <= 1'b0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_reg && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg   <= 1'b0;
         w_data_reg   <= 8'h00;
         w_strb_reg   <= 1'b0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg   <= 1'b1;
         w_data_reg   <= s_axi_wdata[7:0];
         w_strb_reg   <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
         w_held_reg   <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held_reg && !s_axi_bvalid;
      end
   end

   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= hpc_pkg::AXI_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (mapped(wr_idx) && aw_addr_reg[1:0] == 2'h0) ? hpc_pkg::AXI_OKAY : hpc_pkg::AXI_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // only byte lane 0 carries data; a write without it changes nothing
   function automatic logic hit(input logic [7:0] idx);
      hit = wr_fire && w_strb_reg && aw_addr_reg[1:0] == 2'h0 && wr_idx == idx;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cal_ctrl_reg    <= hpc_pkg::RST_CAL_CTRL;
         lock_fault_reg  <= hpc_pkg::RST_LOCK_FAULT;
         prop_high_reg   <= hpc_pkg::RST_PROP_HIGH;
         prop_low_reg    <= hpc_pkg::RST_PROP_LOW;
         integ_high_reg  <= hpc_pkg::RST_INTEG_HIGH;
         integ_low_reg   <= hpc_pkg::RST_INTEG_LOW;
         brake_pause_reg <= hpc_pkg::RST_BRAKE_PAUSE;
         drive_lvl_reg   <= hpc_pkg::RST_DRIVE_LVL;
         config_reg      <= hpc_pkg::RST_CONFIG;
         irq_mask_reg    <= 8'h00;
      end else begin
         // a register moves only on its own write, so a mode write leaves the rest
         if (hit(hpc_pkg::IDX_CAL_CTRL))    cal_ctrl_reg    <= w_data_reg & hpc_pkg::MASK_CAL_CTRL;
         if (hit(hpc_pkg::IDX_LOCK_FAULT))  lock_fault_reg  <= w_data_reg;
         if (hit(hpc_pkg::IDX_PROP_HIGH))   prop_high_reg   <= w_data_reg;
         if (hit(hpc_pkg::IDX_PROP_LOW))    prop_low_reg    <= w_data_reg;
         if (hit(hpc_pkg::IDX_INTEG_HIGH))  integ_high_reg  <= w_data_reg;
         if (hit(hpc_pkg::IDX_INTEG_LOW))   integ_low_reg   <= w_data_reg;
         if (hit(hpc_pkg::IDX_BRAKE_PAUSE)) brake_pause_reg <= w_data_reg & hpc_pkg::MASK_BRAKE_PAUSE;
         if (hit(hpc_pkg::IDX_DRIVE_LVL))   drive_lvl_reg   <= w_data_reg;
         if (hit(hpc_pkg::IDX_CONFIG))      config_reg      <= w_data_reg & hpc_pkg::MASK_CONFIG;
         if (hit(hpc_pkg::IDX_IRQ_MASK))    irq_mask_reg    <= w_data_reg & hpc_pkg::MASK_IRQ;
      end
   end

   // play control write is also the start/stop command
   assign go_wr1 = hit(hpc_pkg::IDX_PLAY_CTRL) && w_data_reg[hpc_pkg::BIT_GO];
   assign go_wr0 = hit(hpc_pkg::IDX_PLAY_CTRL) && !w_data_reg[hpc_pkg::BIT_GO];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         play_ctrl_reg <= hpc_pkg::RST_PLAY_CTRL;
      end else if (hit(hpc_pkg::IDX_PLAY_CTRL)) begin
         play_ctrl_reg <= w_data_reg & hpc_pkg::MASK_PLAY_CTRL;
      end else if (state_reg == hpc_pkg::ST_PLAY && playback_done) begin
         play_ctrl_reg[hpc_pkg::BIT_GO] <= 1'b0;
      end
   end

   // mode is taken at start; a change during playback is ignored
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         hpc_pkg::ST_IDLE, hpc_pkg::ST_STANDBY: begin
            if (go_wr1 && w_data_reg[2:0] != hpc_pkg::MODE_INACTIVE) state_next = hpc_pkg::ST_PLAY;
            else if (go_wr0) state_next = hpc_pkg::ST_IDLE;
         end
         hpc_pkg::ST_PLAY: begin
            if (go_wr0) state_next = hpc_pkg::ST_IDLE;
            else if (playback_done) state_next = play_ctrl_reg[hpc_pkg::BIT_STANDBY] ? hpc_pkg::ST_STANDBY
               : hpc_pkg::ST_IDLE;
         end
         default: state_next = hpc_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg       <= hpc_pkg::ST_IDLE;
         active_mode     <= hpc_pkg::MODE_INACTIVE;
         playback_active <= 1'b0;
         standby_active  <= 1'b0;
      end else begin
         state_reg       <= state_next;
         playback_active <= state_next == hpc_pkg::ST_PLAY;
         standby_active  <= state_next == hpc_pkg::ST_STANDBY;
         if (state_reg != hpc_pkg::ST_PLAY && state_next == hpc_pkg::ST_PLAY) begin
            active_mode <= w_data_reg[2:0];
         end else if (state_next != hpc_pkg::ST_PLAY) begin
            active_mode <= hpc_pkg::MODE_INACTIVE;
         end
      end
   end

   always_comb begin
      case (lock_fault_reg[1:0])
         2'h1: fault_next = backemf_uv < hpc_pkg::BEMF_UV_1;
         2'h2: fault_next = backemf_uv < hpc_pkg::BEMF_UV_2;
         2'h3: fault_next = backemf_uv < hpc_pkg::BEMF_UV_3;
         default: fault_next = 1'b0;
      endcase
   end

   assign lock_next = track_error < {8'h00, lock_fault_reg[7:2], 2'h0};

   hpc_drive_scale u_scale (
      .accel_en           (config_reg[hpc_pkg::BIT_ACCEL]),
      .direct_drive_level (drive_lvl_reg),
      .scale_q7           (scale_next)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         freq_locked      <= 1'b0;
         backemf_fault    <= 1'b0;
         factor_update_en <= 1'b0;
         drive_scale      <= 8'h00;
         loop_cfg         <= '0;
      end else begin
         freq_locked   <= lock_next;
         backemf_fault <= fault_next && state_reg == hpc_pkg::ST_PLAY;
         factor_update_en <= factor_update_req && !cal_ctrl_reg[hpc_pkg::BIT_HOLD]
                             && !(cal_ctrl_reg[hpc_pkg::BIT_INHIBIT] && state_reg == hpc_pkg::ST_PLAY);
         // outside direct override the scale is held at zero
         drive_scale <= (state_reg == hpc_pkg::ST_PLAY && active_mode == hpc_pkg::MODE_DIRECT) ? scale_next : 8'h00;
         loop_cfg.prop_coeff  <= {prop_high_reg, prop_low_reg};
         loop_cfg.integ_coeff <= {integ_high_reg, integ_low_reg};
         loop_cfg.brake_cutoff_threshold   <= brake_pause_reg[6:4];
         loop_cfg.tracking_pause_threshold <= brake_pause_reg[3:0];
         loop_cfg.lock_error_limit         <= lock_fault_reg[7:2];
      end
   end

   assign irq_events = {state_reg == hpc_pkg::ST_PLAY && playback_done, lock_next && !freq_locked,
                        fault_next && !backemf_fault && state_reg == hpc_pkg::ST_PLAY};
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   // a read clears status, but an event in the same cycle survives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_reg <= 8'h00;
      end else if (rd_fire && rd_idx == hpc_pkg::IDX_IRQ_STATUS && s_axi_araddr[1:0] == 2'h0) begin
         irq_status_reg <= {5'h00, irq_events};
      end else begin
         irq_status_reg <= irq_status_reg | {5'h00, irq_events};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_reg & irq_mask_reg);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= hpc_pkg::AXI_OKAY;
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= (mapped(rd_idx) && s_axi_araddr[1:0] == 2'h0) ? hpc_pkg::AXI_OKAY : hpc_pkg::AXI_SLVERR;
         case (s_axi_araddr[1:0] == 2'h0 ? rd_idx : 8'hff)
            hpc_pkg::IDX_CAL_CTRL:    s_axi_rdata <= {24'h0, cal_ctrl_reg};
            hpc_pkg::IDX_LOCK_FAULT:  s_axi_rdata <= {24'h0, lock_fault_reg};
            hpc_pkg::IDX_PROP_HIGH:   s_axi_rdata <= {24'h0, prop_high_reg};
            hpc_pkg::IDX_PROP_LOW:    s_axi_rdata <= {24'h0, prop_low_reg};
            hpc_pkg::IDX_INTEG_HIGH:  s_axi_rdata <= {24'h0, integ_high_reg};
            hpc_pkg::IDX_INTEG_LOW:   s_axi_rdata <= {24'h0, integ_low_reg};
            hpc_pkg::IDX_BRAKE_PAUSE: s_axi_rdata <= {24'h0, brake_pause_reg};
            hpc_pkg::IDX_PLAY_CTRL:   s_axi_rdata <= {24'h0, play_ctrl_reg};
            hpc_pkg::IDX_DRIVE_LVL:   s_axi_rdata <= {24'h0, drive_lvl_reg};
            hpc_pkg::IDX_CONFIG:      s_axi_rdata <= {24'h0, config_reg};
            hpc_pkg::IDX_IRQ_STATUS:  s_axi_rdata <= {24'h0, irq_status_reg};
            hpc_pkg::IDX_IRQ_MASK:    s_axi_rdata <= {24'h0, irq_mask_reg};
            hpc_pkg::IDX_STATE:       s_axi_rdata <= {27'h0, backemf_fault, freq_locked, active_mode == 3'h0,
               state_reg};
            default:                  s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end else begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== sim/hpc_act_model.sv ====
/*
 actuator model: tracking error, back-emf and a sequence-finished pulse.
 assumes the bench sets the levels.
*/
`default_nettype none
module hpc_act_model #(parameter int PLAY_LEN = 20) (
   input  wire logic        aclk,
   input  wire logic        playback_active,
   input  wire logic [15:0] err_cmd,
   input  wire logic [15:0] bemf_cmd,
   input  wire logic        end_en,
   output var  logic [15:0] track_error = 16'h0,
   output var  logic [15:0] backemf_uv = 16'h0,
   output var  logic        playback_done = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   always @(posedge aclk) track_error <= err_cmd;
   // an undriven coil shows no back-emf
   always @(posedge aclk) backemf_uv <= playback_active ? bemf_cmd : 16'h0;
   always @(posedge aclk) begin
      playback_done <= 1'b0;
      cnt <= playback_active ? cnt + 1 : 0;
      if (playback_active && end_en && cnt == PLAY_LEN) begin
         playback_done <= 1'b1;
         cnt <= 0;
      end
   end
endmodule
`default_nettype wire

// ==== sim/hpc_regs_props.sv ====
/*
 checker bound to hpc_regs.
 assumes one clock and a synchronous active-low reset.
*/
`default_nettype none
module hpc_regs_props (
   input wire logic                   aclk,
   input wire logic                   aresetn,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic                   s_axi_bvalid,
   input wire logic                   s_axi_bready,
   input wire logic [1:0]             s_axi_bresp,
   input wire logic [31:0]            s_axi_rdata,
   input wire logic                   s_axi_rvalid,
   input wire logic                   s_axi_rready,
   input wire logic [15:0]            track_error,
   input wire logic                   freq_locked,
   input wire logic                   backemf_fault,
   input wire logic                   playback_active,
   input wire logic                   standby_active,
   input wire logic [2:0]             active_mode,
   input wire logic [7:0]             drive_scale,
   input wire hpc_pkg::hpc_loop_cfg_t loop_cfg,
   input wire logic                   irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // three quiet samples let the one-cycle lag of freq_locked behind track_error settle
   AST_LOCK: assert property ((!$changed(track_error) && !$changed(loop_cfg.lock_error_limit)) [*3]
      |-> freq_locked == (track_error < {8'h0, loop_cfg.lock_error_limit, 2'b00})) else $error("lock flag wrong");
   AST_FLT: assert property (backemf_fault |-> playback_active || $past(playback_active))
      else $error("fault outside playback");
   AST_EXCL: assert property (!(playback_active && standby_active)) else $error("play and standby");
   AST_MODE: assert property (!playback_active [*2] |-> active_mode == 3'h0) else $error("mode while idle");
   AST_DRV: assert property (!playback_active [*3] |-> drive_scale == 8'h00) else $error("drive while idle");
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_RHI: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
   AST_ARR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
   cover property ($rose(playback_active));
   cover property ($rose(standby_active));
   cover property ($rose(backemf_fault));
   cover property ($rose(irq));
endmodule
bind hpc_regs hpc_regs_props u_hpc_regs_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .track_error, .freq_locked,
   .backemf_fault, .playback_active, .standby_active, .active_mode, .drive_scale, .loop_cfg, .irq);
`default_nettype wire

// ==== sim/testbench.sv ====
/*
 axi4-lite bench for the haptic control registers.
 assumes the design, checker and actuator model are compiled with it.
*/
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic                   s_axi_arvalid = 0, s_axi_rready = 0, factor_update_req = 0, end_en = 0;
   logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, playback_done;
   logic                   factor_update_en, freq_locked, backemf_fault, playback_active, standby_active, irq;
   logic [7:0]             s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, drive_scale, rd;
   logic [31:0]            s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]             s_axi_wstrb = 4'hf;
   logic [1:0]             s_axi_bresp, s_axi_rresp, rsp;
   logic [15:0]            track_error, backemf_uv, err_cmd = 16'h0, bemf_cmd = 16'h0;
   logic [2:0]             active_mode;
   hpc_pkg::hpc_loop_cfg_t loop_cfg;
   int                     n_fail = 0, total_checks = 0, cyc = 0;
   // index, reset value, read-back after writing all ones (0x22 is not written)
   logic [23:0] tbl [10] = '{24'h1640c0, 24'h1781ff, 24'h1c0eff, 24'h1d20ff, 24'h1e03ff, 24'h1f20ff,
                             24'h20437f, 24'h220000, 24'h2300ff, 24'h300404};
   logic [8:0]  ftab [4] = '{9'h100, 9'h080, 9'h0c0, 9'h140};
   logic [15:0] thr [3] = '{16'h1324, 16'h6cfc, 16'hc2ec};
   always #2.5 aclk = ~aclk;
   hpc_regs u_hpc_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .track_error,
      .backemf_uv, .playback_done, .factor_update_req, .factor_update_en, .freq_locked, .backemf_fault,
      .playback_active, .standby_active, .active_mode, .drive_scale, .loop_cfg, .irq);
   hpc_act_model u_hpc_act_model (.aclk, .playback_active, .err_cmd, .bemf_cmd, .end_en,
      .track_error, .backemf_uv, .playback_done);
   task automatic chk(input string nm, input logic [63:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] idx, d);
      @(posedge aclk);
      s_axi_awaddr <= {idx[5:0], 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] idx);
      @(posedge aclk);
      s_axi_araddr <= {idx[5:0], 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata[7:0];
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // a few hundred cycles suffice
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test;
      end
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (tbl[i]) begin
         rdr(tbl[i][23:16]);
         chk("reset value", rd, tbl[i][15:8]);
      end
      foreach (tbl[i]) if (tbl[i][23:16] != 8'h22) wr(tbl[i][23:16], 8'hff);
      foreach (tbl[i]) begin
         rdr(tbl[i][23:16]);
         chk("read back", rd, tbl[i][7:0]);
      end
      rdr(8'h21);
      chk("unmapped read", {rsp, rd}, {2'h2, 8'h0});
      wr(8'h21, 8'hff);
      chk("unmapped write", rsp, 2'h2);
      chk("loop cfg", loop_cfg, {16'hffff, 16'hffff, 3'h7, 4'hf, 6'h3f});
      $display("test registers done");
      wr(8'h32, 8'h07);
      err_cmd <= 16'd252;
      repeat (4) @(posedge aclk);
      rdr(8'h31);
      err_cmd <= 16'd251;
      repeat (4) @(posedge aclk);
      chk("locked irq", {freq_locked, irq}, 2'b11);
      rdr(8'h31);
      chk("lock status", rd & 8'h02, 8'h02);
      repeat (2) @(posedge aclk);
      chk("irq cleared", irq, 1'b0);
      err_cmd <= 16'd252;
      repeat (4) @(posedge aclk);
      chk("unlocked", freq_locked, 1'b0);
      $display("test lock done");
      factor_update_req <= 1'b1;
      foreach (ftab[i]) begin
         wr(8'h16, ftab[i][7:0]);
         repeat (3) @(posedge aclk);
         chk("factor update", factor_update_en, ftab[i][8]);
      end
      wr(8'h23, 8'h7f);
      wr(8'h22, 8'h11);
      repeat (3) @(posedge aclk);
      chk("direct play", {playback_active, active_mode, drive_scale, factor_update_en}, 13'h12fe);
      wr(8'h23, 8'h80);
      repeat (3) @(posedge aclk);
      chk("negative accel", drive_scale, 8'h00);
      wr(8'h30, 8'h00);
      repeat (3) @(posedge aclk);
      chk("negative raw", drive_scale, 8'h80);
      wr(8'h22, 8'h01);
      repeat (3) @(posedge aclk);
      chk("stop", {playback_active, standby_active, drive_scale}, 10'h0);
      for (int m = 2; m < 5; m++) begin
         wr(8'h22, 8'h10 | 8'(m));
         repeat (3) @(posedge aclk);
         chk("mode", {playback_active, active_mode, drive_scale}, {1'b1, 3'(m), 8'h0});
         wr(8'h22, 8'(m));
      end
      wr(8'h22, 8'h10);
      repeat (3) @(posedge aclk);
      chk("inactive go", playback_active, 1'b0);
      end_en <= 1'b1;
      wr(8'h22, 8'h19);
      repeat (40) @(posedge aclk);
      chk("standby", {playback_active, standby_active}, 2'b01);
      rdr(8'h22);
      chk("go cleared", rd, 8'h09);
      wr(8'h22, 8'h11);
      repeat (40) @(posedge aclk);
      chk("idle after", {playback_active, standby_active}, 2'b00);
      rdr(8'h1c);
      chk("coeff kept", rd, 8'hff);
      $display("test playback done");
      end_en <= 1'b0;
      wr(8'h22, 8'h11);
      foreach (thr[i]) begin
         wr(8'h17, 8'hfc + 8'(i + 1));
         bemf_cmd <= thr[i] - 16'h1;
         repeat (4) @(posedge aclk);
         chk("fault", backemf_fault, 1'b1);
         bemf_cmd <= thr[i];
         repeat (4) @(posedge aclk);
         chk("no fault", backemf_fault, 1'b0);
      end
      wr(8'h17, 8'hfc);
      bemf_cmd <= 16'h0;
      repeat (4) @(posedge aclk);
      chk("fault off", backemf_fault, 1'b0);
      wr(8'h22, 8'h01);
      $display("test fault done");
      end_of_test;
   end
endmodule
`default_nettype wire
